// ==== hdl/sfr_bank_pkg.sv ====
// Register map, field layout and reset values of the special register bank
package sfr_bank_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] ADDR_DATA_POINTER_LOW = 8'h82;
    localparam logic [7:0] ADDR_DATA_POINTER_HIGH = 8'h83;
    localparam logic [7:0] ADDR_CORE_CLOCK_DIVIDER = 8'h95;
    localparam logic [7:0] ADDR_AUXILIARY_FUNCTION = 8'ha2;
    localparam logic [7:0] ADDR_INTERRUPT_ENABLE_FIRST = 8'ha8;
    localparam logic [7:0] ADDR_COMPARATOR_CONTROL = 8'hac;
    localparam logic [7:0] ADDR_INTERRUPT_PRIORITY_FIRST = 8'hb8;
    localparam logic [7:0] ADDR_ARITH_PRIMARY_REG = 8'he0;
    localparam logic [7:0] ADDR_FLASH_CONTROL_STATUS = 8'he4;
    localparam logic [7:0] ADDR_FLASH_DATA = 8'he5;
    localparam logic [7:0] ADDR_FLASH_ADDRESS_LOW = 8'he6;
    localparam logic [7:0] ADDR_FLASH_ADDRESS_HIGH = 8'he7;
    localparam logic [7:0] ADDR_INTERRUPT_ENABLE_SECOND = 8'he8;
    localparam logic [7:0] ADDR_SECOND_OPERAND_REG = 8'hf0;
    localparam logic [7:0] RESET_ZERO = 8'h00;
    localparam logic [7:0] RESET_FLASH_STATUS = 8'h70;
    // Writable bits; others are reserved or fixed
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam logic [7:0] MASK_AUXILIARY = 8'hf9;
    localparam logic [7:0] MASK_COMPARATOR = 8'h28;
    localparam logic [7:0] MASK_INT_ENABLE_FIRST = 8'hea;
    localparam logic [7:0] MASK_INT_ENABLE_SECOND = 8'h06;
    localparam logic [7:0] MASK_INT_PRIORITY_FIRST = 8'h6a;
    // Comparator field positions
    localparam int CMP_ENABLE_BIT = 5;
    localparam int CMP_INPUT_SELECT_BIT = 3;
    localparam int CMP_OUTPUT_BIT = 1;
    localparam int CMP_CHANGE_FLAG_BIT = 0;
    // Flash status field positions
    localparam int FLASH_BUSY_BIT = 7;
    localparam int FLASH_HVA_BIT = 3;
    localparam int FLASH_HVE_BIT = 2;
    localparam int FLASH_SV_BIT = 1;
    localparam int FLASH_OI_BIT = 0;
    localparam logic [7:0] FLASH_STATUS_FIXED = 8'h70;
    typedef enum logic [1:0] {CMD_IDLE, CMD_WRITE, CMD_READ} core_cmd_type;
endpackage

// ==== hdl/sfr_bank_if.sv ====
// Core-to-register-bank access link
`timescale 1ns/10ps
interface sfr_bank_if;
    logic writeStrobe;
    logic readStrobe;
    logic [7:0] address;
    logic [7:0] writeData;
    logic [7:0] readData;
    logic readValid;
    modport device (input writeStrobe, input readStrobe, input address, input writeData,
        output readData, output readValid);
    modport core (output writeStrobe, output readStrobe, output address, output writeData,
        input readData, input readValid);
endinterface

// ==== hdl/sfr_register_bank.sv ====
// Special register bank: storage, fixed bits and flash status/command split
`timescale 1ns/10ps
module sfr_register_bank (
    input wire logic clk,
    input wire logic rstn,
    sfr_bank_if.device bus,
    input wire logic flashBusy,
    input wire logic [3:0] flashFlags,
    input wire logic comparatorOutput,
    input wire logic comparatorChangeSet,
    output logic [15:0] dataPointer,
    output logic [7:0] coreClockDivider,
    output logic [15:0] flashAddress,
    output logic [7:0] flashData,
    output logic [7:0] flashCommandCode,
    output logic flashCommandStrobe,
    output logic comparatorEnable,
    output logic comparatorInputSelect
);
    import sfr_bank_pkg::*;

    localparam int NREG = 14;
    localparam logic [7:0] ADDRS [NREG] = '{
        ADDR_DATA_POINTER_LOW,
        ADDR_DATA_POINTER_HIGH,
        ADDR_CORE_CLOCK_DIVIDER,
        ADDR_AUXILIARY_FUNCTION,
        ADDR_INTERRUPT_ENABLE_FIRST,
        ADDR_COMPARATOR_CONTROL,
        ADDR_INTERRUPT_PRIORITY_FIRST,
        ADDR_ARITH_PRIMARY_REG,
        ADDR_FLASH_CONTROL_STATUS,
        ADDR_FLASH_DATA,
        ADDR_FLASH_ADDRESS_LOW,
        ADDR_FLASH_ADDRESS_HIGH,
        ADDR_INTERRUPT_ENABLE_SECOND,
        ADDR_SECOND_OPERAND_REG
    };
    localparam logic [7:0] MASKS [NREG] = '{
        MASK_FULL,
        MASK_FULL,
        MASK_FULL,
        MASK_AUXILIARY,
        MASK_INT_ENABLE_FIRST,
        MASK_COMPARATOR,
        MASK_INT_PRIORITY_FIRST,
        MASK_FULL,
        RESET_ZERO, // Flash slot stores nothing; commands leave the bank
        MASK_FULL,
        MASK_FULL,
        MASK_FULL,
        MASK_INT_ENABLE_SECOND,
        MASK_FULL
    };
    localparam int IDX_DPL = 0;
    localparam int IDX_DPH = 1;
    localparam int IDX_DIV = 2;
    localparam int IDX_CMP = 5;
    localparam int IDX_FLASH = 8;
    localparam int IDX_FDATA = 9;
    localparam int IDX_FADL = 10;
    localparam int IDX_FADH = 11;

    logic [7:0] regs_ff [NREG];
    logic [NREG-1:0] hit;
    logic [7:0] flashStatus_ff;
    logic cmpOut_ff;
    logic cmpFlag_ff;
    logic [7:0] readData_ff;
    logic readValid_ff;
    logic [7:0] cmdCode_ff;
    logic cmdStrobe_ff;
    logic [1:0] busySync_ff;
    logic [3:0] flagSync0_ff;
    logic [3:0] flagSync1_ff;
    logic [1:0] cmpSync_ff;

    // Decode of each mapped address; no hit reads back as zero
    for (genvar i = 0; i < NREG; i++) begin : g_dec
        assign hit[i] = (bus.address == ADDRS[i]);
    end

    wire writeCmp = bus.writeStrobe && hit[IDX_CMP];
    wire writeFlash = bus.writeStrobe && hit[IDX_FLASH];

    // Masked storage: reserved and fixed-zero bits never latch
    for (genvar i = 0; i < NREG; i++) begin : g_reg
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                regs_ff[i] <= RESET_ZERO;
            end else if (bus.writeStrobe && hit[i]) begin
                regs_ff[i] <= bus.writeData & MASKS[i];
            end
        end
    end

    // Flash engine pins are asynchronous; busy and flags share two stages
    // so that all status bits move on the same edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busySync_ff <= 2'h0;
            flagSync0_ff <= 4'h0;
            flagSync1_ff <= 4'h0;
        end else begin
            busySync_ff <= {busySync_ff[0], flashBusy};
            flagSync0_ff <= flashFlags;
            flagSync1_ff <= flagSync0_ff;
        end
    end

    // Comparator output comes from analog logic, so it is synchronised too
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmpSync_ff <= 2'h0;
        end else begin
            cmpSync_ff <= {cmpSync_ff[0], comparatorOutput};
        end
    end

    // Busy (bit 7) and the four fault flags (bits 3:0) are merged with the fixed-one reserved bits 6:4
    wire [7:0] busyField = {7'h00, busySync_ff[1]} << FLASH_BUSY_BIT;
    wire [7:0] flagField = {4'h0, flagSync1_ff};
    wire [7:0] nxt_flashStatus = FLASH_STATUS_FIXED | busyField | flagField;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flashStatus_ff <= RESET_FLASH_STATUS;
            cmpOut_ff <= 1'b0;
        end else begin
            flashStatus_ff <= nxt_flashStatus;
            cmpOut_ff <= cmpSync_ff[1];
        end
    end

    // Set wins over software clear, so a change is never lost
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmpFlag_ff <= 1'b0;
        end else if (comparatorChangeSet) begin
            cmpFlag_ff <= 1'b1;
        end else if (writeCmp && !bus.writeData[CMP_CHANGE_FLAG_BIT]) begin
            cmpFlag_ff <= 1'b0;
        end
    end

    // Command write is taken whole and pulsed out
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmdCode_ff <= RESET_ZERO;
            cmdStrobe_ff <= 1'b0;
        end else begin
            cmdStrobe_ff <= writeFlash;
            if (writeFlash) begin
                cmdCode_ff <= bus.writeData;
            end
        end
    end

    logic [7:0] nxt_readData;
    always_comb begin
        nxt_readData = RESET_ZERO;
        for (int i = 0; i < NREG; i++) begin
            if (hit[i]) begin
                nxt_readData = regs_ff[i];
            end
        end
        if (hit[IDX_FLASH]) begin
            nxt_readData = flashStatus_ff;
        end
        if (hit[IDX_CMP]) begin
            nxt_readData = (regs_ff[IDX_CMP] & MASK_COMPARATOR)
                | ({7'h00, cmpOut_ff} << CMP_OUTPUT_BIT)
                | ({7'h00, cmpFlag_ff} << CMP_CHANGE_FLAG_BIT);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            readData_ff <= RESET_ZERO;
            readValid_ff <= 1'b0;
        end else begin
            readValid_ff <= bus.readStrobe;
            if (bus.readStrobe) begin
                readData_ff <= nxt_readData;
            end
        end
    end

    assign bus.readData = readData_ff;
    assign bus.readValid = readValid_ff;
    assign dataPointer = {regs_ff[IDX_DPH], regs_ff[IDX_DPL]};
    assign coreClockDivider = regs_ff[IDX_DIV];
    assign flashAddress = {regs_ff[IDX_FADH], regs_ff[IDX_FADL]};
    assign flashData = regs_ff[IDX_FDATA];
    assign flashCommandCode = cmdCode_ff;
    assign flashCommandStrobe = cmdStrobe_ff;
    assign comparatorEnable = regs_ff[IDX_CMP][CMP_ENABLE_BIT];
    assign comparatorInputSelect = regs_ff[IDX_CMP][CMP_INPUT_SELECT_BIT];
endmodule

// ==== hdl/sfr_core_port.sv ====
// Core-side end: turns user requests into register bank accesses
`timescale 1ns/10ps
module sfr_core_port (
    input wire logic clk,
    input wire logic rstn,
    sfr_bank_if.core bus,
    input wire logic reqWrite,
    input wire logic reqRead,
    input wire logic [7:0] reqAddress,
    input wire logic [7:0] reqData,
    output logic reqReady,
    output logic [7:0] respData,
    output logic respValid
);
    import sfr_bank_pkg::*;

    core_cmd_type state_ff;
    logic [7:0] addr_ff;
    logic [7:0] wdata_ff;
    logic [7:0] resp_ff;
    logic respValid_ff;

    // Only mapped addresses may be issued; others are dropped here
    function automatic logic mapped(input logic [7:0] a);
        return a == ADDR_DATA_POINTER_LOW || a == ADDR_DATA_POINTER_HIGH
            || a == ADDR_CORE_CLOCK_DIVIDER || a == ADDR_AUXILIARY_FUNCTION
            || a == ADDR_INTERRUPT_ENABLE_FIRST || a == ADDR_COMPARATOR_CONTROL
            || a == ADDR_INTERRUPT_PRIORITY_FIRST || a == ADDR_ARITH_PRIMARY_REG
            || a == ADDR_FLASH_CONTROL_STATUS || a == ADDR_FLASH_DATA
            || a == ADDR_FLASH_ADDRESS_LOW || a == ADDR_FLASH_ADDRESS_HIGH
            || a == ADDR_INTERRUPT_ENABLE_SECOND || a == ADDR_SECOND_OPERAND_REG;
    endfunction

    // Flag bit kept so that writing one leaves a pending change alone
    localparam logic [7:0] CMP_FLAG_MASK = 8'h01 << CMP_CHANGE_FLAG_BIT;

    // Bits software may set per register; the rest go out as zero
    function automatic logic [7:0] writeMask(input logic [7:0] a);
        case (a)
            ADDR_AUXILIARY_FUNCTION: return MASK_AUXILIARY;
            ADDR_INTERRUPT_ENABLE_FIRST: return MASK_INT_ENABLE_FIRST;
            ADDR_INTERRUPT_ENABLE_SECOND: return MASK_INT_ENABLE_SECOND;
            ADDR_INTERRUPT_PRIORITY_FIRST: return MASK_INT_PRIORITY_FIRST;
            ADDR_COMPARATOR_CONTROL: return MASK_COMPARATOR | CMP_FLAG_MASK;
            default: return MASK_FULL;
        endcase
    endfunction

    wire idle = (state_ff == CMD_IDLE);
    wire okAddr = mapped(reqAddress);
    wire takeWrite = idle && reqWrite && okAddr;
    wire takeRead = idle && reqRead && !reqWrite && okAddr;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= CMD_IDLE;
            addr_ff <= RESET_ZERO;
            wdata_ff <= RESET_ZERO;
        end else begin
            case (state_ff)
                CMD_IDLE: begin
                    if (takeWrite) begin
                        state_ff <= CMD_WRITE;
                    end else if (takeRead) begin
                        state_ff <= CMD_READ;
                    end
                    addr_ff <= reqAddress;
                    // Reserved bits forced to zero before write
                    wdata_ff <= reqData & writeMask(reqAddress);
                end
                CMD_WRITE: state_ff <= CMD_IDLE;
                CMD_READ: begin
                    if (bus.readValid) begin
                        state_ff <= CMD_IDLE;
                    end
                end
                default: state_ff <= CMD_IDLE;
            endcase
        end
    end

    logic readIssued_ff;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            resp_ff <= RESET_ZERO;
            respValid_ff <= 1'b0;
            readIssued_ff <= 1'b0;
        end else begin
            respValid_ff <= (state_ff == CMD_READ) && bus.readValid;
            readIssued_ff <= takeRead;
            if ((state_ff == CMD_READ) && bus.readValid) begin
                resp_ff <= bus.readData;
            end
        end
    end

    assign bus.writeStrobe = (state_ff == CMD_WRITE);
    assign bus.readStrobe = readIssued_ff;
    assign bus.address = addr_ff;
    assign bus.writeData = wdata_ff;
    assign reqReady = idle;
    assign respData = resp_ff;
    assign respValid = respValid_ff;
endmodule

// ==== tb/sfr_register_bank_sva.sv ====
// Link checker between the core-side end and the register bank
`timescale 1ns/10ps
module sfr_register_bank_sva (
    input wire logic clk,
    input wire logic rstn,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    input wire logic [7:0] address,
    input wire logic [7:0] writeData,
    input wire logic [7:0] readData,
    input wire logic readValid
);
    logic [7:0] shadow_ff [0:255];
    logic [7:0] expRd_ff;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    function automatic logic [7:0] rmask(input logic [7:0] a);
        case (a)
            8'h82, 8'h83, 8'h95, 8'he0, 8'he5, 8'he6, 8'he7, 8'hf0: return 8'hff;
            8'ha2: return 8'hf9;
            8'ha8: return 8'hea;
            8'he8: return 8'h06;
            8'hb8: return 8'h6a;
            8'hac: return 8'h28;
            default: return 8'h00;
        endcase
    endfunction
    wire logic mapped = rmask(address) != 8'h00 || address == 8'he4;
    wire logic plain = rmask(address) == 8'hff;
    wire logic masked = rmask(address) inside {8'hf9, 8'hea, 8'h06, 8'h6a};
    // Shadow of stored bits; hardware-fed bits are left out
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 256; i++) shadow_ff[i] <= 8'h00;
            expRd_ff <= 8'h00;
        end else begin
            if (writeStrobe) shadow_ff[address] <= writeData;
            expRd_ff <= shadow_ff[address] & rmask(address);
        end
    end
    sequence s_read;
        readStrobe;
    endsequence
    sequence s_read_at(logic [7:0] a);
        readStrobe && address == a;
    endsequence
    property p_mapped_only; (readStrobe || writeStrobe) |-> mapped; endproperty
    property p_read_answer; s_read |=> readValid; endproperty
    property p_status_fixed; s_read_at(8'he4) |=> readData[6:4] == 3'b111; endproperty
    property p_cmp_zero; s_read_at(8'hac) |=> (readData & 8'hd4) == 8'h00; endproperty
    property p_cmp_fields; s_read_at(8'hac) |=> (readData & 8'h28) == expRd_ff; endproperty
    property p_plain; readStrobe && plain |=> readData == expRd_ff; endproperty
    property p_masked; readStrobe && masked |=> readData == expRd_ff; endproperty
    property p_write_silent; writeStrobe |=> !readValid; endproperty
    a_mapped_only: assert property (p_mapped_only)
        else $error("strobe on an unmapped address");
    a_read_answer: assert property (p_read_answer)
        else $error("read not answered next cycle");
    a_status_fixed: assert property (p_status_fixed)
        else $error("flash status bits 6:4 not one");
    a_cmp_zero: assert property (p_cmp_zero)
        else $error("comparator fixed bits not zero");
    a_cmp_fields: assert property (p_cmp_fields)
        else $error("comparator enable or select wrong");
    a_plain: assert property (p_plain)
        else $error("byte register readback wrong");
    a_masked: assert property (p_masked)
        else $error("masked register readback wrong");
    a_write_silent: assert property (p_write_silent)
        else $error("write produced a read answer");
endmodule

// ==== tb/test_sfr_register_bank.sv ====
// Bench for the register bank driven through its core-side end
`timescale 1ns/10ps
module test_sfr_register_bank;
    import sfr_bank_pkg::*;
    logic clk, rstn, reqWrite, reqRead, reqReady, respValid, flashBusy, comparatorOutput;
    logic comparatorChangeSet, flashCommandStrobe, comparatorEnable, comparatorInputSelect, vld;
    logic [7:0] reqAddress, reqData, respData, coreClockDivider, flashData, flashCommandCode;
    logic [7:0] d, got;
    logic [15:0] dataPointer, flashAddress;
    logic [3:0] flashFlags;
    int errors, check_count, cmdCount;
    logic [7:0] regs [12] = '{8'h82, 8'h83, 8'h95, 8'ha2, 8'ha8, 8'hb8, 8'he0, 8'he5, 8'he6,
        8'he7, 8'he8, 8'hf0};
    logic [7:0] sh [256];
    sfr_bank_if bankLink();
    sfr_register_bank sfr_register_bank_inst (.clk(clk), .rstn(rstn), .bus(bankLink.device),
        .flashBusy(flashBusy), .flashFlags(flashFlags), .comparatorOutput(comparatorOutput),
        .comparatorChangeSet(comparatorChangeSet), .dataPointer(dataPointer),
        .coreClockDivider(coreClockDivider), .flashAddress(flashAddress), .flashData(flashData),
        .flashCommandCode(flashCommandCode), .flashCommandStrobe(flashCommandStrobe),
        .comparatorEnable(comparatorEnable), .comparatorInputSelect(comparatorInputSelect));
    sfr_core_port sfr_core_port_inst (.clk(clk), .rstn(rstn), .bus(bankLink.core),
        .reqWrite(reqWrite), .reqRead(reqRead), .reqAddress(reqAddress), .reqData(reqData),
        .reqReady(reqReady), .respData(respData), .respValid(respValid));
    sfr_register_bank_sva sfr_register_bank_sva_inst (.clk(clk), .rstn(rstn),
        .writeStrobe(bankLink.writeStrobe), .readStrobe(bankLink.readStrobe),
        .address(bankLink.address), .writeData(bankLink.writeData),
        .readData(bankLink.readData), .readValid(bankLink.readValid));
    function automatic logic [7:0] wmask(input logic [7:0] a);
        case (a)
            8'ha2: return 8'hf9;
            8'ha8: return 8'hea;
            8'he8: return 8'h06;
            8'hb8: return 8'h6a;
            default: return 8'hff;
        endcase
    endfunction
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (flashCommandStrobe === 1'b1) cmdCount++;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    // Request raised only while ready, so it is taken at the very next edge
    task automatic send(input logic wr, input logic [7:0] a, input logic [7:0] v);
        int n;
        n = 0;
        while (reqReady !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        reqAddress = a;
        reqData = v;
        reqWrite = wr;
        reqRead = !wr;
        @(posedge clk);
        #1;
        reqWrite = 0;
        reqRead = 0;
        n = 0;
        while (!wr && respValid !== 1'b1 && n < 6) begin
            @(posedge clk);
            #1;
            n++;
        end
        vld = respValid;
        got = respData;
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        {rstn, reqWrite, reqRead, flashBusy, comparatorOutput, comparatorChangeSet} = '0;
        {reqAddress, reqData, flashFlags, errors, check_count, cmdCount} = '0;
        void'($urandom(79802));
        repeat (5) @(posedge clk);
        #1;
        rstn = 1;
        foreach (regs[i]) begin
            send(0, regs[i], 8'h00);
            chk(16'(got), 16'h0000, "reset value");
        end
        send(0, 8'he4, 8'h00);
        chk(16'(got), 16'h0070, "flash status reset");
        $display("test reset done");
        for (int r = 0; r < 3; r++) begin
            foreach (regs[i]) begin
                d = (r == 0) ? 8'hff : 8'($urandom);
                sh[regs[i]] = d;
                send(1, regs[i], d);
                send(0, regs[i], 8'h00);
                chk(16'(got), 16'(d & wmask(regs[i])), "readback");
            end
        end
        chk(dataPointer, {sh[8'h83], sh[8'h82]}, "data pointer");
        chk(flashAddress, {sh[8'he7], sh[8'he6]}, "flash address");
        chk({coreClockDivider, flashData}, {sh[8'h95], sh[8'he5]}, "divider or data");
        $display("test readback done");
        d = 8'($urandom);
        send(1, 8'he4, d);
        send(0, 8'he4, 8'h00);
        chk(16'(got), 16'h0070, "status changed by command");
        chk({flashCommandCode, 8'(cmdCount)}, {d, 8'h01}, "command code");
        foreach (regs[i]) begin
            flashBusy = regs[i][0];
            flashFlags = (i == 0) ? 4'hf : 4'($urandom);
            repeat (4) @(posedge clk);
            #1;
            send(0, 8'he4, 8'h00);
            chk(16'(got), 16'({flashBusy, 3'b111, flashFlags}), "flash status");
        end
        $display("test flash done");
        send(1, 8'hac, 8'hff);
        send(0, 8'hac, 8'h00);
        chk(16'(got), 16'h0028, "comparator write");
        comparatorOutput = 1;
        comparatorChangeSet = 1;
        @(posedge clk);
        #1;
        comparatorChangeSet = 0;
        repeat (4) @(posedge clk);
        #1;
        send(0, 8'hac, 8'h00);
        chk(16'(got), 16'h002b, "comparator flag set");
        send(1, 8'hac, 8'h08);
        send(0, 8'hac, 8'h00);
        chk(16'(got), 16'h000a, "comparator flag clear");
        chk(16'({comparatorEnable, comparatorInputSelect}), 16'h0001, "comparator outs");
        $display("test comparator done");
        // Unmapped place: write must vanish and read must get no answer
        send(1, 8'h81, 8'h5a);
        send(0, 8'h81, 8'h00);
        chk(16'({vld, reqReady}), 16'h0001, "unmapped access answered");
        $display("test unmapped done");
        stop_test();
    end
    initial begin
        #300000;
        errors++;
        stop_test();
    end
endmodule
